// [bench/tb_top.sv]
// self-checking bench for the torque reference compensation block
`timescale 1ns/10ps
module tb_top;
    import trc_pkg::*;

    logic                                 sys_clk_in;
    logic                                 rst_n_in;
    logic                                 ce;
    logic                                 sample;
    logic signed [SPD_W-1:0]              speed;
    logic signed [TQ_W-1:0]               tq_in;
    logic signed [POS_W-1:0]              pos_in;
    trc_fric_cfg_t                        fric;
    logic [PRM_W-1:0]                     ld_pct;
    logic [PRM_W-1:0]                     obs_gain;
    trc_mf_cfg_t                          mf;
    logic                                 pos_mode;
    logic                                 manual;
    logic                                 closed;
    trc_notch_cfg_t [NOTCH_N-1:0]         notch;
    logic signed [TQ_W-1:0]               tq_out;
    logic                                 tq_valid;
    logic signed [POS_W-1:0]              pos_out;
    logic signed [TQ_W-1:0]               spd_ff;
    logic signed [TQ_W-1:0]               tq_ff;
    logic                                 mf_act;
    logic                                 los_act;
    logic signed [TQ_W-1:0]               obs;
    int                                   n_errors;
    int                                   cmp_count;
    int                                   cyc;

    trc_top u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .ce_in(ce), .sample_in(sample), .speed_in(speed),
        .torque_ref_in(tq_in), .pos_ref_in(pos_in), .fric_cfg_in(fric),
        .load_torque_comp_pct_in(ld_pct), .load_observer_gain_in(obs_gain),
        .mf_cfg_in(mf), .pos_mode_in(pos_mode), .manual_tune_in(manual),
        .full_closed_in(closed), .notch_cfg_in(notch),
        .torque_ref_out(tq_out), .torque_valid_out(tq_valid),
        .pos_ref_out(pos_out), .mf_speed_ff_out(spd_ff),
        .mf_torque_ff_out(tq_ff), .mf_active_out(mf_act),
        .los_active_out(los_act), .observer_torque_out(obs));

    trc_partner u_part (.clk_in(sys_clk_in), .valid_in(tq_valid),
        .sample_out(sample), .speed_out(speed), .torque_out(tq_in),
        .pos_out(pos_in));

    initial sys_clk_in = 1'b0;
    always #4 sys_clk_in = ~sys_clk_in;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // run length is under six hundred cycles; the ceiling leaves wide margin
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(posedge sys_clk_in);
        #1;
        rst_n_in = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        rst_n_in = 1'b1;
        check("tq_after_reset", tq_out, 32'h0);
    endtask

    // one word through, fixed four-cycle answer and one-cycle strobe
    task automatic go(input int spd, input int tq, input int pos);
        int   lat;
        logic p;
        u_part.send(spd[15:0], tq[15:0], pos, lat, p);
        check("latency", lat, 32'h4);
        check("valid_pulse", p, 32'h1);
    endtask

    task automatic t_coulomb();
        int sp[5] = '{50, -50, 10, -10, 11};
        int ex[5] = '{1100, 900, 1000, 1000, 1100};
        fric = '{16'h0064, 16'h000a, 16'h0000};
        for (int i = 0; i < 5; i++) begin
            go(sp[i], 1000, 0);
            check("coulomb", tq_out, ex[i]);
        end
    endtask

    task automatic t_viscous();
        fric = '{16'h0000, 16'h0000, 16'h0028};
        go(1024, 0, 0);
        check("visc_pos", tq_out, 40);
        go(-1024, 0, 0);
        check("visc_neg", tq_out, -40);
        fric.viscous_comp_coeff = 16'h0050;
        go(1024, 100, 0);
        check("visc_slope", tq_out, 180);
        fric.viscous_comp_coeff = 16'h0028;
        go(32767, 32000, 0);
        check("sat_hi", tq_out, 32767);
        go(-32767, -32000, 0);
        check("sat_lo", tq_out, -32768);
    endtask

    // full gain makes the estimate equal the previous output exactly
    task automatic t_observer();
        fric = '{16'h0000, 16'h0000, 16'h0000};
        obs_gain = 16'h1000;
        go(0, 1000, 0);
        go(0, 1000, 0);
        check("obs_track", obs, 1000);
        obs_gain = 16'h0000;
        ld_pct = 16'h0064;
        go(0, 1000, 0);
        check("obs_frozen", obs, 1000);
        check("load_comp", tq_out, 1999);
        ld_pct = 16'h0000;
    endtask

    task automatic t_model();
        do_reset();
        go(0, 0, 32'h1234_5678);
        check("mf_off", mf_act, 0);
        check("pos_pass", pos_out, 32'h1234_5678);
        check("ff_off", spd_ff, 0);
        mf.model_follow_select = MF_LOS;
        {pos_mode, manual, closed} = 3'b110;
        do_reset();
        go(0, 0, 0);
        check("mf_los", {mf_act, los_act}, 32'h3);
        check("ff_src0", {spd_ff, tq_ff}, 0);
        mf.speed_ff_source = FF_SRC_MF;
        mf.torque_ff_source = FF_SRC_MF;
        mf.model_follow_select = MF_OFF;
        go(0, 0, 0);
        check("restart_only", mf_act, 1);
        closed = 1'b1;
        go(0, 0, 0);
        check("closed_off", mf_act, 0);
        check("ff_inact", {spd_ff, tq_ff}, 0);
        {closed, manual} = 2'b00;
        go(0, 0, 0);
        check("auto_off", mf_act, 0);
        mf.model_follow_select = MF_ON;
        manual = 1'b1;
        do_reset();
        go(0, 0, 0);
        check("mf_on", {mf_act, los_act}, 32'h2);
        go(0, 0, 32'h0000_1000);
        check("mf_model_pos", pos_out, 0);
        check("tq_ff_live", tq_ff > 0, 1);
        mf.mf_torque_ff_pct = 16'h0000;
        go(0, 0, 32'h0000_1000);
        check("spd_ff_live", spd_ff > 0, 1);
        check("tq_ff_pct0", tq_ff, 0);
    endtask

    // enable low for two cycles mid-flight stretches the answer by two
    task automatic t_enable();
        int   lat;
        logic p;
        fork
            u_part.send(16'h0000, 16'h0064, 32'h0000_0000, lat, p);
            begin
                repeat (2) @(posedge sys_clk_in);
                #1;
                ce = 1'b0;
                repeat (2) @(posedge sys_clk_in);
                #1;
                ce = 1'b1;
            end
        join
        check("ce_stretch", lat, 32'h6);
        check("ce_pulse", p, 32'h1);
        check("ce_data", tq_out, 32'h64);
    endtask

    // tone at the first notch's centre: depth 0 cuts it, 31 (held at 23) keeps it
    task automatic t_notch();
        int tone[16] = '{0, 383, 707, 924, 1000, 924, 707, 383,
                         0, -383, -707, -924, -1000, -924, -707, -383};
        int peak;
        int mag;
        peak = 0;
        notch[0] = '{16'h03e8, 5'h00, 4'hf};
        for (int i = 0; i < 48; i++) begin
            go(0, tone[i % 16], 0);
            mag = tq_out;
            if (mag < 0) begin
                mag = -mag;
            end
            if (i >= 32 && mag > peak) begin
                peak = mag;
            end
        end
        check("notch_cut", peak < 150, 1);
        for (int i = 0; i < NOTCH_N; i++) begin
            notch[i] = '{16'h03e8, 5'h1f, 4'hf};
        end
        for (int i = 0; i < 16; i++) begin
            go(0, tone[i], 0);
            check("notch_keep", tq_out, tone[i]);
        end
    endtask

    initial begin
        rst_n_in = 1'b0;
        ce = 1'b1;
        fric = '0;
        ld_pct = 16'h0000;
        obs_gain = 16'h0000;
        mf = '{MF_OFF, 16'h0100, 16'h0100, 16'h0064, 16'h0064,
               2'h0, 2'h0};
        {pos_mode, manual, closed} = 3'b000;
        for (int i = 0; i < NOTCH_N; i++) begin
            notch[i] = '{NOTCH_OFF_FREQ, DEPTH_MAX, 4'h0};
        end
        do_reset();
        go(0, 1234, 0);
        check("bypass", tq_out, 1234);
        t_coulomb();
        t_viscous();
        t_observer();
        t_enable();
        t_notch();
        t_model();
        give_verdict();
    end
endmodule

// [bench/trc_partner.sv]
// far side model: speed loop word source and torque loop sink
`timescale 1ns/10ps
module trc_partner (
    input  wire logic                         clk_in,
    input  wire logic                         valid_in,
    output logic                              sample_out,
    output logic signed [trc_pkg::SPD_W-1:0]  speed_out,
    output logic signed [trc_pkg::TQ_W-1:0]   torque_out,
    output logic signed [trc_pkg::POS_W-1:0]  pos_out
);
    import trc_pkg::*;

    initial begin
        sample_out = 1'b0;
        speed_out  = 16'h0000;
        torque_out = 16'h0000;
        pos_out    = 32'h0000_0000;
    end

    // one word per control cycle; lines go stale (inverted) once taken
    task automatic send(input logic signed [SPD_W-1:0] spd,
                        input logic signed [TQ_W-1:0]  tq,
                        input logic signed [POS_W-1:0] pos,
                        output int lat, output logic pulse1);
        lat = 0;
        @(posedge clk_in);
        #1;
        sample_out = 1'b1;
        speed_out  = spd;
        torque_out = tq;
        pos_out    = pos;
        @(posedge clk_in);
        #1;
        sample_out = 1'b0;
        speed_out  = ~spd;
        torque_out = ~tq;
        pos_out    = ~pos;
        while (valid_in !== 1'b1 && lat < 12) begin
            @(posedge clk_in);
            #1;
            lat++;
        end
        // valid seen after an edge is taken by the sink at the next edge
        @(posedge clk_in);
        lat++;
        #1;
        pulse1 = (valid_in === 1'b0);
    endtask
endmodule

// [hdl/trc_pkg.sv]
// constants, modes and carrier types for torque reference compensation
package trc_pkg;
    localparam int TQ_W    = 16;
    localparam int SPD_W   = 16;
    localparam int POS_W   = 32;
    localparam int PRM_W   = 16;
    localparam int NOTCH_N = 3;
    localparam int ACC_W   = 48;

    localparam logic [15:0] NOTCH_OFF_FREQ = 16'h1388;
    localparam logic [4:0]  DEPTH_MAX      = 5'h17;
    localparam logic [3:0]  WIDTH_MAX      = 4'hf;
    localparam logic [1:0]  MF_OFF         = 2'h0;
    localparam logic [1:0]  MF_ON          = 2'h1;
    localparam logic [1:0]  MF_LOS         = 2'h2;
    localparam logic [1:0]  FF_SRC_MF      = 2'h1;

    localparam int COEF_FRAC   = 14;
    localparam int PCT_RECIP   = 655;
    localparam int PCT_SHIFT   = 16;
    localparam int DEPTH_RECIP = 2849;
    localparam int VISC_SHIFT  = 10;
    localparam int OBS_SHIFT   = 12;
    localparam int MF_SHIFT    = 12;
    localparam int TWO_PI_Q14  = 102944;
    localparam int FREQ_FRAC   = 8;
    localparam int Q_SHIFT     = 11;
    localparam int PIPE_DEPTH  = 4;

    typedef enum logic [1:0] {
        ST_BOOT = 2'b01,
        ST_RUN  = 2'b10
    } trc_state_t;

    typedef struct packed {
        logic [PRM_W-1:0] coulomb_comp_level;
        logic [PRM_W-1:0] coulomb_speed_deadband;
        logic [PRM_W-1:0] viscous_comp_coeff;
    } trc_fric_cfg_t;

    typedef struct packed {
        logic [1:0]       model_follow_select;
        logic [PRM_W-1:0] model_follow_gain;
        logic [PRM_W-1:0] model_follow_gain_correction;
        logic [PRM_W-1:0] mf_speed_ff_pct;
        logic [PRM_W-1:0] mf_torque_ff_pct;
        logic [1:0]       speed_ff_source;
        logic [1:0]       torque_ff_source;
    } trc_mf_cfg_t;

    typedef struct packed {
        logic [15:0] freq;
        logic [4:0]  depth;
        logic [3:0]  width;
    } trc_notch_cfg_t;
endpackage

// [hdl/trc_top.sv]
// torque reference compensation, model following and notch cascade
// Behaviour
// [RULE_01] coulomb term takes its sign from the motor speed
// [RULE_02] coulomb term is zero while speed lies inside the dead band
// [RULE_03] viscous term is speed times the viscous coefficient
// [RULE_04] load term is observer output times the load percentage
// [RULE_05] observer bandwidth follows the observer gain setting
// [RULE_06] selection 0 off, 1 model following, 2 plus oscillation; restart only
// [RULE_07] model follower makes position reference plus speed and torque ff
// [RULE_08] gain sets response speed, correction sets damping
// [RULE_09] speed and torque ff scaled by their percentage settings
// [RULE_10] ff percentages apply only when ff source selects one
// [RULE_11] model following only in position mode, manual tuning, not closed
// [RULE_12] three notch filters, each enabled alone, cascaded in series
// [RULE_13] each notch uses its own frequency, depth and width
// [RULE_14] notch frequency 5000 bypasses that notch
// [RULE_15] notch depth accepted from 0 to 23
// [RULE_16] notch width accepted from 0 to 15
// [RULE_17] software enables model following before selecting it as ff source
// [RULE_18] compensation summed once per cycle, saturated, then notched
`timescale 1ns/10ps
module trc_top #(
    parameter int CTRL_RATE_HZ  = 16000,
    parameter int INERTIA_SHIFT = 4
) (
    input  wire logic                                   sys_clk_in,
    input  wire logic                                   rst_n_in,
    input  wire logic                                   ce_in,
    input  wire logic                                   sample_in,
    input  wire logic signed [trc_pkg::SPD_W-1:0]       speed_in,
    input  wire logic signed [trc_pkg::TQ_W-1:0]        torque_ref_in,
    input  wire logic signed [trc_pkg::POS_W-1:0]       pos_ref_in,
    input  wire trc_pkg::trc_fric_cfg_t                 fric_cfg_in,
    input  wire logic [trc_pkg::PRM_W-1:0]              load_torque_comp_pct_in,
    input  wire logic [trc_pkg::PRM_W-1:0]              load_observer_gain_in,
    input  wire trc_pkg::trc_mf_cfg_t                   mf_cfg_in,
    input  wire logic                                   pos_mode_in,
    input  wire logic                                   manual_tune_in,
    input  wire logic                                   full_closed_in,
    input  wire trc_pkg::trc_notch_cfg_t [trc_pkg::NOTCH_N-1:0] notch_cfg_in,
    output logic signed [trc_pkg::TQ_W-1:0]             torque_ref_out,
    output logic                                        torque_valid_out,
    output logic signed [trc_pkg::POS_W-1:0]            pos_ref_out,
    output logic signed [trc_pkg::TQ_W-1:0]             mf_speed_ff_out,
    output logic signed [trc_pkg::TQ_W-1:0]             mf_torque_ff_out,
    output logic                                        mf_active_out,
    output logic                                        los_active_out,
    output logic signed [trc_pkg::TQ_W-1:0]             observer_torque_out
);
    import trc_pkg::*;

    localparam logic signed [ACC_W-1:0] TQ_MAX = 48'sh00000000_7fff;
    localparam logic signed [ACC_W-1:0] TQ_MIN = 48'shffffffff_8000;
    localparam logic signed [ACC_W-1:0] F_MUL  =
        ACC_W'((TWO_PI_Q14 * (2 ** FREQ_FRAC)) / CTRL_RATE_HZ);
    localparam logic signed [ACC_W-1:0] PCT_K  = ACC_W'(PCT_RECIP);
    localparam logic signed [ACC_W-1:0] DEP_K  = ACC_W'(DEPTH_RECIP);

    function automatic logic signed [TQ_W-1:0] sat_tq(
        input logic signed [ACC_W-1:0] v
    );
        if (v > TQ_MAX) begin
            return TQ_MAX[TQ_W-1:0];
        end else if (v < TQ_MIN) begin
            return TQ_MIN[TQ_W-1:0];
        end
        return v[TQ_W-1:0];
    endfunction

    function automatic logic signed [ACC_W-1:0] ext_u(
        input logic [PRM_W-1:0] u
    );
        return {{(ACC_W-PRM_W){1'b0}}, u};
    endfunction

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    wire logic smp = sample_in & ce_in;

    // friction terms
    wire logic signed [ACC_W-1:0] spd_x   = ACC_W'(speed_in);
    wire logic signed [ACC_W-1:0] abs_spd = speed_in[SPD_W-1] ? -spd_x : spd_x;
    wire logic in_band = abs_spd <= ext_u(fric_cfg_in.coulomb_speed_deadband);
    wire logic signed [ACC_W-1:0] coul_mag =
        ext_u(fric_cfg_in.coulomb_comp_level);
    wire logic signed [ACC_W-1:0] coul_term = in_band ? '0 :       // RULE_02
        (speed_in[SPD_W-1] ? -coul_mag : coul_mag);                // RULE_01
    wire logic signed [ACC_W-1:0] visc_term =
        (spd_x * ext_u(fric_cfg_in.viscous_comp_coeff))
        >>> VISC_SHIFT;                                            // RULE_03

    // load torque observer: disturbance = applied torque minus inertia term
    logic signed [TQ_W-1:0]  obs_est;
    logic signed [SPD_W-1:0] spd_prev;
    wire logic signed [ACC_W-1:0] accel_tq =
        (spd_x - ACC_W'(spd_prev)) <<< INERTIA_SHIFT;
    wire logic signed [ACC_W-1:0] obs_res =
        ACC_W'(torque_ref_out) - accel_tq - ACC_W'(obs_est);
    wire logic signed [ACC_W-1:0] obs_step =
        (obs_res * ext_u(load_observer_gain_in)) >>> OBS_SHIFT;   // RULE_05
    wire logic signed [TQ_W-1:0] next_obs_est =
        sat_tq(ACC_W'(obs_est) + obs_step);
    wire logic signed [ACC_W-1:0] load_term =
        (ACC_W'(obs_est) * ext_u(load_torque_comp_pct_in) * PCT_K)
        >>> PCT_SHIFT;                                             // RULE_04
    wire logic signed [ACC_W-1:0] comp_sum = ACC_W'(torque_ref_in)
        + coul_term + visc_term + load_term;                       // RULE_18

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            obs_est  <= '0;
            spd_prev <= '0;
        end else if (smp) begin
            obs_est  <= next_obs_est;
            spd_prev <= speed_in;
        end
    end

    // model-following selection latched once after reset release
    trc_state_t  state;
    logic [1:0]  mf_sel;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state  <= ST_BOOT;
            mf_sel <= MF_OFF;
        end else if (ce_in) begin
            unique case (state)
                ST_BOOT: begin
                    mf_sel <= mf_cfg_in.model_follow_select;       // RULE_06
                    state  <= ST_RUN;
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    wire logic mf_sel_on = (mf_sel == MF_ON) || (mf_sel == MF_LOS); // RULE_06
    wire logic mf_act = mf_sel_on && (state == ST_RUN) && pos_mode_in
        && manual_tune_in && !full_closed_in;                      // RULE_11

    // second order model: gain is stiffness, correction is damping
    logic signed [POS_W-1:0] mf_pos;
    logic signed [POS_W-1:0] mf_vel;
    wire logic signed [ACC_W-1:0] pos_err =
        ACC_W'(pos_ref_in) - ACC_W'(mf_pos);
    wire logic signed [ACC_W-1:0] mf_acc =
        (pos_err * ext_u(mf_cfg_in.model_follow_gain)
        - ACC_W'(mf_vel) * ext_u(mf_cfg_in.model_follow_gain_correction))
        >>> MF_SHIFT;                                              // RULE_08
    wire logic signed [ACC_W-1:0] vel_sum = ACC_W'(mf_vel) + mf_acc;
    wire logic signed [POS_W-1:0] next_mf_vel = vel_sum[POS_W-1:0];
    wire logic signed [ACC_W-1:0] pos_sum =
        ACC_W'(mf_pos) + (ACC_W'(mf_vel) >>> MF_SHIFT);
    wire logic signed [POS_W-1:0] next_mf_pos = pos_sum[POS_W-1:0];
    wire logic signed [ACC_W-1:0] spd_ff_raw =
        (ACC_W'(mf_vel) * ext_u(mf_cfg_in.mf_speed_ff_pct) * PCT_K)
        >>> PCT_SHIFT;                                             // RULE_09
    wire logic signed [ACC_W-1:0] tq_ff_raw =
        (mf_acc * ext_u(mf_cfg_in.mf_torque_ff_pct) * PCT_K)
        >>> PCT_SHIFT;                                             // RULE_09
    // source check here too, so a premature ff select gives zero, not junk
    wire logic spd_ff_on = mf_act && (mf_cfg_in.speed_ff_source == FF_SRC_MF);
    wire logic tq_ff_on  = mf_act && (mf_cfg_in.torque_ff_source == FF_SRC_MF);

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mf_pos <= '0;
            mf_vel <= '0;
        end else if (smp && mf_act) begin
            mf_pos <= next_mf_pos;                                 // RULE_07
            mf_vel <= next_mf_vel;
        end else if (smp) begin
            mf_pos <= pos_ref_in;
            mf_vel <= '0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pos_ref_out      <= '0;
            mf_speed_ff_out  <= '0;
            mf_torque_ff_out <= '0;
            mf_active_out    <= 1'b0;
            los_active_out   <= 1'b0;
        end else if (ce_in) begin
            mf_active_out  <= mf_act;
            los_active_out <= mf_act && (mf_sel == MF_LOS);
            if (sample_in) begin
                pos_ref_out      <= mf_act ? mf_pos : pos_ref_in;  // RULE_07
                mf_speed_ff_out  <= spd_ff_on ? sat_tq(spd_ff_raw)
                    : '0;                                          // RULE_10
                mf_torque_ff_out <= tq_ff_on ? sat_tq(tq_ff_raw)
                    : '0;                                          // RULE_10
            end
        end
    end

    // saturated sum enters the notch cascade, one stage per clock
    logic signed [TQ_W-1:0] stg_dat [0:NOTCH_N];
    logic                   stg_vld [0:NOTCH_N];

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            stg_dat[0] <= '0;
            stg_vld[0] <= 1'b0;
        end else if (ce_in) begin
            stg_vld[0] <= sample_in;
            if (sample_in) begin
                stg_dat[0] <= sat_tq(comp_sum);                    // RULE_18
            end
        end
    end

    // state variable notch; stable only while freq stays well below rate/6
    for (genvar i = 0; i < NOTCH_N; i++) begin : g_notch            // RULE_12
        trc_notch_cfg_t cfg;
        logic signed [ACC_W-1:0] lp;
        logic signed [ACC_W-1:0] bp;
        assign cfg = notch_cfg_in[i];
        wire logic bypass = (cfg.freq == NOTCH_OFF_FREQ);          // RULE_14
        wire logic [4:0] dep = (cfg.depth > DEPTH_MAX) ? DEPTH_MAX
            : cfg.depth;                                           // RULE_15
        wire logic [3:0] wid = (cfg.width > WIDTH_MAX) ? WIDTH_MAX
            : cfg.width;                                           // RULE_16
        wire logic signed [ACC_W-1:0] f_prod = ext_u(cfg.freq) * F_MUL;
        wire logic signed [ACC_W-1:0] f_c = f_prod >>> FREQ_FRAC;  // RULE_13
        wire logic signed [ACC_W-1:0] q_c =
            ACC_W'({wid, 1'b1}) <<< (Q_SHIFT - 1);                 // RULE_13
        wire logic signed [ACC_W-1:0] x = ACC_W'(stg_dat[i]);
        wire logic signed [ACC_W-1:0] rej = (q_c * bp) >>> COEF_FRAC;
        // low pass moves first and high pass sees it, else the loop diverges
        wire logic signed [ACC_W-1:0] next_lp =
            lp + ((f_c * bp) >>> COEF_FRAC);
        wire logic signed [ACC_W-1:0] hp = x - next_lp - rej;
        wire logic signed [ACC_W-1:0] next_bp =
            bp + ((f_c * hp) >>> COEF_FRAC);
        // depth 0 removes the band fully, depth 23 leaves it untouched
        // signed copy, so a negative band term is not shifted as unsigned
        wire logic signed [ACC_W-1:0] keep = ACC_W'(DEPTH_MAX - dep);
        wire logic signed [ACC_W-1:0] cut =
            (rej * keep * DEP_K) >>> PCT_SHIFT;                    // RULE_13
        wire logic signed [TQ_W-1:0] y = bypass ? stg_dat[i]
            : sat_tq(x - cut);

        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                lp             <= '0;
                bp             <= '0;
                stg_dat[i+1]   <= '0;
                stg_vld[i+1]   <= 1'b0;
            end else if (ce_in) begin
                stg_vld[i+1] <= stg_vld[i];
                if (stg_vld[i]) begin
                    stg_dat[i+1] <= y;
                    lp <= bypass ? '0 : next_lp;
                    bp <= bypass ? '0 : next_bp;
                end
            end
        end

        a_notch_bypass: assert property (ce_in && stg_vld[i] && bypass
            |=> stg_dat[i+1] == $past(stg_dat[i])) // RULE_14
            else $error("bypassed notch altered the sample");
        c_notch_live: cover property (ce_in && stg_vld[i] && !bypass
            && bp != 0);
    end

    assign torque_ref_out      = stg_dat[NOTCH_N];
    assign torque_valid_out    = stg_vld[NOTCH_N];
    assign observer_torque_out = obs_est;

    a_coul_band: assert property (smp && in_band |-> coul_term == 0) // RULE_02
        else $error("coulomb term nonzero inside dead band");
    a_coul_sign: assert property (smp && !in_band
        && fric_cfg_in.coulomb_comp_level != 0
        |-> coul_term[ACC_W-1] == speed_in[SPD_W-1]) // RULE_01
        else $error("coulomb sign does not follow speed");
    a_visc_zero: assert property (speed_in == 0 |-> visc_term == 0) // RULE_03
        else $error("viscous term nonzero at zero speed");
    a_load_zero: assert property (load_torque_comp_pct_in == 0
        |-> load_term == 0) // RULE_04
        else $error("load term nonzero at zero percentage");
    a_obs_frozen: assert property (smp && load_observer_gain_in == 0
        |=> obs_est == $past(obs_est)) // RULE_05
        else $error("observer moved with zero gain");
    a_sel_stable: assert property (state == ST_RUN // RULE_06
        |=> $stable(mf_sel))
        else $error("model follow selection changed without restart");
    a_mf_gate: assert property (ce_in && full_closed_in
        |=> !mf_active_out) // RULE_11
        else $error("model following active in closed loop");
    a_ff_source: assert property (smp
        && mf_cfg_in.speed_ff_source != FF_SRC_MF
        |=> mf_speed_ff_out == 0) // RULE_10
        else $error("speed ff nonzero with other source");
    a_pipe_latency: assert property (smp ##1 ce_in [*4]
        |-> torque_valid_out) // RULE_18
        else $error("torque output not valid four cycles after sample");

    c_band_hit: cover property (smp && in_band
        && fric_cfg_in.coulomb_comp_level != 0);
    c_mf_run: cover property (smp && mf_act && mf_speed_ff_out != 0);
    c_los_run: cover property (los_active_out);
endmodule
